// file: swpa_pkg.sv
// Shared constants and types for the secondary-word phase adjust block.
// Assumes a 200 MHz aclk and an AXI4-Lite master with 32-bit data.
package swpa_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PERIOD = 8'h00;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_DAC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [15:0] PERIOD_RST = 16'h61A8;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [15:0] PERIOD_MIN = 16'h0004;
  localparam int STAT_ARMED_BIT = 16;
  localparam int STAT_SECPEND_BIT = 17;
  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int DAC_LSB = 2;
  localparam int SEL_HI_BIT = 15;
  localparam int SEL_LO_BIT = 14;
  localparam int BIT_ONE = 1;
  localparam int BIT_ZERO = 0;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Decoded action of a secondary word
  typedef enum logic [1:0] {
    ADJ_NONE = 2'b00,
    ADJ_LATER = 2'b01,
    ADJ_EARLIER = 2'b10
  } swpa_adj_e;
  // Serial shifter states
  typedef enum logic [0:0] {
    SH_IDLE = 1'b0,
    SH_BUSY = 1'b1
  } swpa_sh_e;
  // Pins arriving from the DSP side
  typedef struct packed {
    logic sclk;
    logic frame_sync_n;
    logic din;
    logic prog_pin_hi;
    logic prog_pin_lo;
  } swpa_link_s;
endpackage : swpa_pkg

// file: swpa_top.sv
// Secondary-word decoder, one-shot sample phase shifter and serial port.
// Assumes link pins are asynchronous to aclk and slow enough to oversample.
//
// Notes on behaviour
// - Undecoded selector and pin combinations do nothing.
// - Each primary word: take DAC bits 15..2; every word sends ADC.
// - Selector 01: shift later, pins ignored.
// - Selector 10: shift earlier, pins ignored.
// - Negative phase value reverses shift direction.
// - Selector 11, pins 01: shift later.
// - Selector 11, pins 10: shift earlier.
// - Secondary frame pulse half period after fall.
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module swpa_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link pins
  input wire swpa_pkg::swpa_link_s link_in,
  output logic dout,
  output logic sec_frame_pulse,
  // Converter side
  input wire logic [15:0] adc_sample,
  output logic sample_strobe,
  output logic [13:0] dac_data,
  output logic dac_valid
);
  import swpa_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  swpa_link_s meta_q;
  swpa_link_s sync_q;
  logic sclk_d;
  logic fs_d;
  // Two flops on every pin; only sync_q is looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '1;
      sync_q <= '1;
      sclk_d <= 1'b1;
      fs_d <= 1'b1;
    end else begin
      meta_q <= link_in;
      sync_q <= meta_q;
      sclk_d <= sync_q.sclk;
      fs_d <= sync_q.frame_sync_n;
    end
  end
  wire sclk_rise = sync_q.sclk & ~sclk_d;
  wire sclk_fall = ~sync_q.sclk & sclk_d;
  wire fs_fall = ~sync_q.frame_sync_n & fs_d;
  wire fs_rise = sync_q.frame_sync_n & ~fs_d;

  // ----------------------------------------------------------------
  // Registers over AXI4-Lite
  // ----------------------------------------------------------------
  logic [15:0] period;
  logic signed [7:0] phase;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] sec_word;
  logic adj_armed;
  logic sec_pending;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // Address and data latch separately, either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      period <= PERIOD_RST;
      phase <= PHASE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb; // Strobes are only valid with wvalid
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= AXI_OKAY;
        // Too short a period would break the half-period pulse
        if (aw_addr == ADDR_PERIOD && w_strb[0] && w_strb[1]) begin
          period <= (w_data[15:0] < PERIOD_MIN) ? PERIOD_MIN : w_data[15:0];
        end else if (aw_addr == ADDR_PHASE) begin
          if (w_strb[0]) phase <= w_data[7:0];
        end else if (aw_addr != ADDR_DAC && aw_addr != ADDR_STATUS) begin
          s_axi_bresp <= AXI_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read side answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr)
        ADDR_PERIOD: s_axi_rdata <= {16'h0000, period};
        ADDR_PHASE: s_axi_rdata <= {24'h000000, phase};
        ADDR_DAC: s_axi_rdata <= {18'h00000, dac_data};
        ADDR_STATUS: s_axi_rdata <= {14'h0000, sec_pending, adj_armed, sec_word};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial word shifter
  // ----------------------------------------------------------------
  swpa_sh_e sh_state;
  logic [4:0] bit_cnt;
  logic [15:0] rx_sr;
  logic [15:0] tx_sr;
  logic [15:0] adc_hold;
  logic word_done;
  logic is_secondary;
  // Word opens on frame-sync fall, bits taken on sclk fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_state <= SH_IDLE;
      bit_cnt <= 5'd0;
      rx_sr <= 16'h0000;
      tx_sr <= 16'h0000;
      dout <= 1'b0;
      word_done <= 1'b0;
      is_secondary <= 1'b0;
    end else begin
      word_done <= 1'b0;
      unique case (sh_state)
        SH_IDLE: if (fs_fall) begin
          sh_state <= SH_BUSY;
          bit_cnt <= 5'd0;
          is_secondary <= sec_pending;
          tx_sr <= {adc_hold[14:0], 1'b0};
          dout <= adc_hold[15];
        end
        SH_BUSY: begin
          if (sclk_fall) begin
            rx_sr <= {rx_sr[14:0], sync_q.din};
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'(WORD_W - 1)) begin
              sh_state <= SH_IDLE;
              word_done <= 1'b1;
            end
          end
          // Data changes on the rising edge, clear of the capture edge
          if (sclk_rise && bit_cnt != 5'd0) begin
            dout <= tx_sr[15];
            tx_sr <= {tx_sr[14:0], 1'b0};
          end
        end
      endcase
    end
  end
  wire [15:0] rx_word = rx_sr;
  // DAC bits out of every primary word, low two bits are control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_data <= 14'h0000;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= word_done & ~is_secondary;
      if (word_done && !is_secondary) dac_data <= rx_word[15:DAC_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Secondary word decode
  // ----------------------------------------------------------------
  swpa_adj_e dec;
  logic [1:0] sel;
  logic [1:0] pins;
  assign sel = {rx_word[SEL_HI_BIT], rx_word[SEL_LO_BIT]};
  assign pins = {sync_q.prog_pin_hi, sync_q.prog_pin_lo};
  always_comb begin
    dec = ADJ_NONE;
    unique case (sel)
      2'b00: dec = ADJ_NONE;
      2'b01: dec = ADJ_LATER;
      2'b10: dec = ADJ_EARLIER;
      2'b11: begin
        if (pins == 2'b01) dec = ADJ_LATER;
        else if (pins == 2'b10) dec = ADJ_EARLIER;
      end
    endcase
  end
  swpa_adj_e pend_adj;
  logic signed [17:0] adj_shift;
  logic adj_used;
  logic [15:0] half_cnt;
  // Pending request waits for frame-sync rise, then arms one reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_word <= 16'h0000;
      pend_adj <= ADJ_NONE;
      adj_armed <= 1'b0;
      adj_shift <= 18'sd0;
    end else begin
      if (word_done && is_secondary) begin
        sec_word <= rx_word;
        pend_adj <= dec;
      end else if (fs_rise && pend_adj != ADJ_NONE) begin
        pend_adj <= ADJ_NONE;
        adj_armed <= 1'b1;
        // Signed phase: a negative value turns the direction round
        adj_shift <= (pend_adj == ADJ_LATER) ? 18'(phase) : -18'(phase);
      end else if (adj_used) begin
        adj_armed <= 1'b0;
      end
    end
  end
  // Secondary frame pulse half a period after the primary falls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_pending <= 1'b0;
      half_cnt <= 16'h0000;
      sec_frame_pulse <= 1'b0;
    end else begin
      sec_frame_pulse <= 1'b0;
      if (word_done && !is_secondary) begin
        sec_pending <= rx_word[BIT_ONE] & rx_word[BIT_ZERO];
      end else if (word_done) begin
        sec_pending <= 1'b0;
      end
      if (fs_fall && !sec_pending) begin
        half_cnt <= {1'b0, period[15:1]} - 16'd2;
      end else if (half_cnt != 16'h0000) begin
        half_cnt <= half_cnt - 16'd1;
        // Fires only if this frame's word asked for it
        if (half_cnt == 16'h0001 && sec_pending) sec_frame_pulse <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sampling timebase
  // ----------------------------------------------------------------
  logic [17:0] smp_cnt;
  logic signed [18:0] reload;
  always_comb begin
    reload = signed'({3'b000, period}) - 19'sd1;
    if (adj_armed) reload = reload + 19'(adj_shift);
    if (reload < 19'sd1) reload = 19'sd1;
  end
  // Counter reloads with the shift applied to one period only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_cnt <= 18'd0;
      sample_strobe <= 1'b0;
      adc_hold <= 16'h0000;
      adj_used <= 1'b0;
    end else begin
      sample_strobe <= (smp_cnt == 18'd0);
      // Arming on the reload cycle itself must not be lost
      adj_used <= (smp_cnt == 18'd0) && adj_armed;
      if (smp_cnt == 18'd0) begin
        smp_cnt <= reload[17:0];
        adc_hold <= adc_sample;
      end else begin
        smp_cnt <= smp_cnt - 18'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sec_word_later;
    word_done && is_secondary && dec == ADJ_LATER;
  endsequence
  chk_undecoded_idle: assert property (
    word_done && is_secondary && (sel == 2'b00 || (sel == 2'b11 && pins[1] == pins[0]))
    |=> pend_adj == ADJ_NONE)
    else $error("undecoded word armed a shift");
  chk_dac_capture: assert property (
    word_done && !is_secondary |=> dac_valid && dac_data == $past(rx_word[15:2]))
    else $error("dac data not taken from word");
  chk_sel_later: assert property (
    word_done && is_secondary && sel == 2'b01 |-> dec == ADJ_LATER)
    else $error("selector 01 not later");
  chk_sel_earlier: assert property (
    word_done && is_secondary && sel == 2'b10 |-> dec == ADJ_EARLIER)
    else $error("selector 10 not earlier");
  chk_later_sign: assert property (
    fs_rise && pend_adj == ADJ_LATER && !word_done |=> adj_armed && adj_shift == 18'($past(phase)))
    else $error("later shift sign wrong");
  chk_pins_later: assert property (
    s_sec_word_later ##0 sel == 2'b11 |-> pins == 2'b01)
    else $error("pins 01 decode wrong");
  chk_pins_earlier: assert property (
    word_done && is_secondary && sel == 2'b11 && pins == 2'b10 |-> dec == ADJ_EARLIER)
    else $error("pins 10 decode wrong");
  chk_sec_pulse_src: assert property (
    sec_frame_pulse |-> $past(sec_pending) && $past(half_cnt) == 16'h0001)
    else $error("secondary pulse without request");
  chk_one_shot: assert property (
    adj_used |=> !adj_armed || $past(fs_rise))
    else $error("shift applied to more than one period");
endmodule : swpa_top

// file: swpa_host.sv
// DSP serial port model: frames 16-bit words towards the block.
// Assumes the block oversamples these pins on its own clock.
`timescale 1ns/10ps
module swpa_host (
  // Link pins
  output swpa_pkg::swpa_link_s link,
  input wire logic dout
);
  import swpa_pkg::*;
  // Idle: serial clock parked high, frame sync high
  initial begin
    link = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  end
  // One frame, 64 ns bit time: data moves on rise, both sides sample on fall
  task automatic send_word(input logic [15:0] w, input logic [1:0] pins,
                           output logic [15:0] rx);
    link.prog_pin_hi = pins[1];
    link.prog_pin_lo = pins[0];
    link.frame_sync_n = 1'b0;
    link.din = w[15];
    for (int i = 15; i >= 0; i--) begin
      #32 link.sclk = 1'b0;
      rx[i] = dout;
      #32 link.sclk = 1'b1;
      if (i > 0) begin
        link.din = w[i-1];
      end
    end
    link.frame_sync_n = 1'b1;
    // Released line shows the inverse, so a stale value never passes
    link.din = ~w[0];
  endtask : send_word
endmodule : swpa_host

// file: secondary_word_phase_adjust_test.sv
// Bench: AXI4-Lite register access plus framed words from a host model.
// Assumes swpa_pkg, swpa_top and swpa_host are compiled first.
`timescale 1ns/10ps
module secondary_word_phase_adjust_test;
  import swpa_pkg::*;
  localparam int P = 1000;
  typedef struct {logic [1:0] sel; logic [1:0] pins; logic [7:0] ph; int d;} swpa_row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dout, sec_pulse, strobe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [13:0] dac_data;
  logic dac_valid;
  logic [15:0] rx;
  swpa_link_s link;
  int err_count, n_tests, cyc, fall_t, sec_gap, k, n_dv;
  int st[$];
  // Selector, pins, phase, expected shift; pins cross-wired to catch misuse
  swpa_row_s rows[9] = '{
    '{2'b00, 2'b01, 8'h05, 0},
    '{2'b01, 2'b10, 8'h05, 5},
    '{2'b10, 2'b01, 8'h05, -5},
    '{2'b01, 2'b00, 8'hFB, -5},
    '{2'b10, 2'b11, 8'hFB, 5},
    '{2'b11, 2'b01, 8'h05, 5},
    '{2'b11, 2'b10, 8'h05, -5},
    '{2'b11, 2'b00, 8'h05, 0},
    '{2'b11, 2'b11, 8'h05, 0}
  };
  swpa_top u_swpa_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_in(link), .dout(dout), .sec_frame_pulse(sec_pulse),
    .adc_sample(16'h5E21), .sample_strobe(strobe), .dac_data(dac_data),
    .dac_valid(dac_valid));
  swpa_host u_swpa_host (.link(link), .dout(dout));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Observers sample on the far edge, clear of the launch edge
  always @(negedge aclk) begin
    cyc++;
    if (strobe === 1'b1) st.push_back(cyc);
    if (sec_pulse === 1'b1) sec_gap = cyc - fall_t;
    if (dac_valid === 1'b1) n_dv++;
  end
  always @(negedge link.frame_sync_n) fall_t = cyc;
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic guard(input bit ok);
    if (!ok) begin
      err_count++;
      $display("ERROR wait expected done seen timeout");
      complete_run();
    end
  endtask : guard
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    // Start just after an edge, never in the step that closed the last call
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    guard(n < 100);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    guard(n < 100);
  endtask : axi_rd
  // Main sequence: table of secondary words, then awkward cases
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_PERIOD, rd, rs);
    check("period_rst", rd, {16'h0000, PERIOD_RST});
    axi_wr(ADDR_PERIOD, P, rs);
    // The counter still runs out the reset period before the new one applies
    st.delete();
    for (k = 0; st.size() < 1 && k < int'(PERIOD_RST) + P; k++) @(negedge aclk);
    guard(k < int'(PERIOD_RST) + P);
    foreach (rows[i]) begin
      axi_wr(ADDR_PHASE, {24'h000000, rows[i].ph}, rs);
      sec_gap = -1;
      n_dv = 0;
      // Primary word with both low bits set asks for a secondary frame
      u_swpa_host.send_word(16'hC3A7, 2'b00, rx);
      repeat (10) @(posedge aclk);
      check("dac_data", dac_data, 14'h30E9);
      check("adc_word", rx, 16'h5E21);
      for (k = 0; sec_gap < 0 && k < P; k++) @(negedge aclk);
      guard(k < P);
      check("sec_gap", sec_gap >= P/2-4 && sec_gap <= P/2+4, 1'b1);
      u_swpa_host.send_word({rows[i].sel, 14'h0000}, rows[i].pins, rx);
      st.delete();
      for (k = 0; st.size() < 4 && k < 5*P; k++) @(negedge aclk);
      guard(k < 5*P);
      check("shift", st[2]-st[0], 2*P+rows[i].d);
      check("one_shot", st[3]-st[2], P);
      check("dac_valid", n_dv, 1);
      axi_rd(ADDR_STATUS, rd, rs);
      check("status", rd, {16'h0000, rows[i].sel, 14'h0000});
      $display("row %0d done", i);
    end
    // Unmapped and read-only places
    axi_rd(ADDR_DAC, rd, rs);
    check("dac_reg", rd, {18'h0, 14'h30E9});
    axi_rd(8'h10, rd, rs);
    check("unmapped_rresp", rs, AXI_SLVERR);
    check("unmapped_rdata", rd, 32'h00000000);
    axi_wr(8'h10, 32'h00000001, rs);
    check("unmapped_bresp", rs, AXI_SLVERR);
    axi_wr(ADDR_STATUS, 32'hFFFFFFFF, rs);
    check("ro_bresp", rs, AXI_OKAY);
    // Reset in mid-run restores the registers
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_PHASE, rd, rs);
    check("phase_rst", rd, {24'h000000, PHASE_RST});
    axi_rd(ADDR_PERIOD, rd, rs);
    check("period_rst2", rd, {16'h0000, PERIOD_RST});
    $display("awkward cases done");
    complete_run();
  end
endmodule : secondary_word_phase_adjust_test
